//--- hw/ajd_top.sv
// audio jack detector core: plug detection, impedance steps, moisture, key, polling
// assumes an analog front end giving the measured impedance and the key comparator
`timescale 1ns/1ps
`include "ajd_defines.svh"
module ajd_top #(
  parameter int         TICK_CYC = `AJD_TICK_CYC,
  parameter logic [6:0] DEV_ADDR = 7'h35
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        jack_sense_in_i,
  input  wire logic [15:0] impedance_ohm_i,
  input  wire logic        key_cmp_i,
  output logic             interrupt_request_n_o,
  output logic             key_press_o,
  output logic             jack_mic_path_o,
  output logic             bias_regulator_on_o
);
  ajd_reg_if rb ();

  ajd_pkg::ajd_core_t s_q;
  ajd_pkg::ajd_core_t s_d;

  // device address value is arbitrary
  ajd_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_oe_o (sda_oe_o),
    .rb       (rb.bus_end)
  );

  function automatic logic [2:0] imp_step(input logic [15:0] ohm);
    logic [2:0] st;
    // thresholds are exclusive upper bounds
    st = `AJD_STEP_LINE;
    if (ohm < `AJD_OHM_STEP0)
      st = 3'h0;
    else if (ohm < `AJD_OHM_STEP1)
      st = 3'h1;
    else if (ohm < `AJD_OHM_STEP2)
      st = 3'h2;
    else if (ohm < `AJD_OHM_STEP3)
      st = 3'h3;
    else if (ohm < `AJD_OHM_STEP4)
      st = 3'h4;
    else if (ohm < `AJD_OHM_STEP5)
      st = 3'h5;
    return st;
  endfunction : imp_step

  // above the line-load ceiling only moisture explains the reading
  function automatic logic is_moist(input logic [15:0] ohm);
    return ohm > `AJD_OHM_LINE_MAX;
  endfunction : is_moist

  // register field times its unit, in millisecond ticks
  function automatic logic [9:0] ms_lim(input logic [3:0] fld, input int unit);
    logic [9:0] lim;
    lim = 10'(fld * unit);
    return lim;
  endfunction : ms_lim

  // status byte: key, moisture, attached, step
  function automatic logic [7:0] status_byte(input ajd_pkg::ajd_core_t s);
    logic [7:0] b;
    b = {2'b00, s.key, s.moist, s.att, s.step};
    return b;
  endfunction : status_byte

  // a new event wins over a clear in the same cycle
  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] clr,
                                           input logic [7:0] set);
    return (cur & ~clr) | set;
  endfunction : flag_next

  // register read mux; unmapped offsets read zero
  always_comb
  begin
    case (rb.addr)
      `AJD_ADDR_CTRL:   rb.rdata = s_q.ctrl;
      `AJD_ADDR_STATUS: rb.rdata = status_byte(s_q);
      `AJD_ADDR_FLAGS:  rb.rdata = s_q.flags;
      `AJD_ADDR_TIMING: rb.rdata = s_q.timing;
      default:          rb.rdata = 8'h00;
    endcase
  end

  always_comb
  begin
    logic [7:0] set;
    logic [7:0] clr;
    logic [7:0] deb_nx;
    logic [7:0] det_lim;
    logic [9:0] on_lim;
    logic [9:0] per_lim;
    logic       headset;
    logic       music;
    logic       poll_on;
    set     = 8'h00;
    clr     = 8'h00;
    headset = 1'b0;
    music   = 1'b0;
    poll_on = 1'b0;
    deb_nx  = s_q.deb_cnt + 1'b1;
    det_lim = 8'(ms_lim(s_q.ctrl[`AJD_CTRL_DET_MSB:`AJD_CTRL_DET_LSB], `AJD_DET_IN_UNIT_MS));
    on_lim  = ms_lim(s_q.timing[`AJD_TIM_POLL_MSB:`AJD_TIM_POLL_LSB], `AJD_POLL_UNIT_MS);
    per_lim = ms_lim(s_q.timing[`AJD_TIM_WAIT_MSB:`AJD_TIM_WAIT_LSB], `AJD_WAIT_UNIT_MS);
    s_d      = s_q;
    s_d.tick = 1'b0;

    // millisecond time base
    if (s_q.presc == 18'(TICK_CYC - 1))
    begin
      s_d.presc = '0;
      s_d.tick  = 1'b1;
    end
    else
      s_d.presc = s_q.presc + 1'b1;

    // status and flag offsets ignore writes
    if (rb.wr)
    begin
      case (rb.addr)
        `AJD_ADDR_CTRL:   s_d.ctrl = rb.wdata;
        `AJD_ADDR_TIMING: s_d.timing = rb.wdata;
        default: ;
      endcase
    end
    // reading the flag register clears it
    if (rb.rd && rb.addr == `AJD_ADDR_FLAGS)
      clr = 8'hff;

    case (s_q.st)
      ajd_pkg::js_no_plug:
        if (!jack_sense_in_i)
        begin
          s_d.st      = ajd_pkg::js_deb_in;
          s_d.deb_cnt = 8'h00;
        end
      ajd_pkg::js_deb_in:
        if (jack_sense_in_i)
          s_d.st = ajd_pkg::js_no_plug;
        else if (s_q.tick)
        begin
          s_d.deb_cnt = deb_nx;
          if (deb_nx >= det_lim)
          begin
            if (is_moist(impedance_ohm_i))
            begin
              s_d.st                   = ajd_pkg::js_moist;
              s_d.moist                = 1'b1;
              set[`AJD_FLAG_MOIST]     = 1'b1;
            end
            else
            begin
              s_d.st                   = ajd_pkg::js_plugged;
              s_d.att                  = 1'b1;
              s_d.step                 = imp_step(impedance_ohm_i);
              set[`AJD_FLAG_ATTACH]    = 1'b1;
            end
          end
        end
      // each tick re-measures; a drying jack becomes an insertion
      ajd_pkg::js_moist:
        if (jack_sense_in_i)
        begin
          s_d.st               = ajd_pkg::js_no_plug;
          s_d.moist            = 1'b0;
          set[`AJD_FLAG_MOIST] = 1'b1;
        end
        else if (s_q.tick && !is_moist(impedance_ohm_i))
        begin
          s_d.st                = ajd_pkg::js_plugged;
          s_d.moist             = 1'b0;
          s_d.att               = 1'b1;
          s_d.step              = imp_step(impedance_ohm_i);
          set[`AJD_FLAG_MOIST]  = 1'b1;
          set[`AJD_FLAG_ATTACH] = 1'b1;
        end
      ajd_pkg::js_plugged:
        if (jack_sense_in_i)
        begin
          s_d.st      = ajd_pkg::js_deb_rem;
          s_d.deb_cnt = 8'h00;
        end
      // attached stays up through a removal bounce
      ajd_pkg::js_deb_rem:
        if (!jack_sense_in_i)
          s_d.st = ajd_pkg::js_plugged;
        else if (s_q.tick)
        begin
          s_d.deb_cnt = deb_nx;
          if (deb_nx >= 8'(`AJD_REM_DEB_MS))
          begin
            s_d.st                = ajd_pkg::js_no_plug;
            s_d.att               = 1'b0;
            s_d.step              = 3'h0;
            set[`AJD_FLAG_DETACH] = 1'b1;
          end
        end
      // unknown state falls back to idle
      default:
        s_d.st = ajd_pkg::js_no_plug;
    endcase

    // headset steps only; line loads carry no key
    headset = (s_q.st == ajd_pkg::js_plugged) && (s_q.step != `AJD_STEP_LINE);
    music   = s_q.ctrl[`AJD_CTRL_MUSIC] && s_q.att;

    // poll counter wraps once per period, mic closed in its first part
    if (!music)
      s_d.poll_cnt = 10'h000;
    else if (s_q.tick)
    begin
      if (s_q.poll_cnt + 1'b1 >= per_lim)
        s_d.poll_cnt = 10'h000;
      else
        s_d.poll_cnt = s_q.poll_cnt + 1'b1;
    end
    poll_on = s_q.poll_cnt < on_lim;

    // hold counter keeps the mic closed after a release
    if (s_q.tick && s_q.hold_cnt != 10'h000)
      s_d.hold_cnt = s_q.hold_cnt - 1'b1;

    // headset only; in polling only in the on window, with key or hold
    s_d.mic = headset && (!music || poll_on || s_q.key || s_q.hold_cnt != 10'h000);

    // key debounce, only while the mic path is closed
    if (!headset)
    begin
      s_d.key_cnt  = 5'h00;
      s_d.hold_cnt = 10'h000;
      if (s_q.key)
        set[`AJD_FLAG_KEY_REL] = 1'b1;
      s_d.key = 1'b0;
    end
    else if (s_q.mic && key_cmp_i != s_q.key)
    begin
      if (s_q.tick)
      begin
        s_d.key_cnt = s_q.key_cnt + 1'b1;
        if (s_q.key_cnt + 1'b1 >= 5'(`AJD_KEY_DEB_MS))
        begin
          s_d.key_cnt = 5'h00;
          s_d.key     = key_cmp_i;
          if (key_cmp_i)
            set[`AJD_FLAG_KEY_PRESS] = 1'b1;
          else
          begin
            set[`AJD_FLAG_KEY_REL] = 1'b1;
            if (music)
              s_d.hold_cnt = 10'(`AJD_KEEP_CLOSED_MS);
          end
        end
      end
    end
    else
      s_d.key_cnt = 5'h00;

    // regulator enable one clock behind the bit
    s_d.ldo   = s_q.ctrl[`AJD_CTRL_LDO];
    s_d.flags = flag_next(s_q.flags, clr, set);
    s_d.irq_n = ~|s_d.flags;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      s_q <= '{st: ajd_pkg::js_no_plug, irq_n: 1'b1, ctrl: `AJD_CTRL_RST,
               timing: `AJD_TIMING_RST, default: '0};
    else
      s_q <= s_d;
  end

  assign sda_o                 = 1'b0;
  assign interrupt_request_n_o = s_q.irq_n;
  assign key_press_o           = s_q.key;
  assign jack_mic_path_o       = s_q.mic;
  assign bias_regulator_on_o   = s_q.ldo;
endmodule : ajd_top

//--- hw/ajd_defines.svh
// register offsets, field positions, reset values and timing of the jack detector
// assumes a 250 MHz core clock and a host reaching the registers over i2c
`ifndef AJD_DEFINES_SVH
`define AJD_DEFINES_SVH

`define AJD_ADDR_CTRL        8'h02
`define AJD_ADDR_STATUS      8'h03
`define AJD_ADDR_FLAGS       8'h04
`define AJD_ADDR_TIMING      8'h0b

`define AJD_CTRL_LDO         0
`define AJD_CTRL_MUSIC       1
`define AJD_CTRL_DET_LSB     4
`define AJD_CTRL_DET_MSB     7
`define AJD_CTRL_RST         8'h50

`define AJD_TIM_POLL_LSB     0
`define AJD_TIM_POLL_MSB     3
`define AJD_TIM_WAIT_LSB     4
`define AJD_TIM_WAIT_MSB     7
`define AJD_TIMING_RST       8'h33

`define AJD_FLAG_ATTACH      0
`define AJD_FLAG_DETACH      1
`define AJD_FLAG_KEY_PRESS   2
`define AJD_FLAG_KEY_REL     3
`define AJD_FLAG_MOIST       4

`define AJD_CLK_PERIOD_NS    4
`define AJD_MS_NS            1000000
`define AJD_TICK_CYC         (`AJD_MS_NS / `AJD_CLK_PERIOD_NS)
`define AJD_DET_IN_UNIT_MS   5
`define AJD_POLL_UNIT_MS     5
`define AJD_WAIT_UNIT_MS     50
`define AJD_REM_DEB_MS       1
`define AJD_KEY_DEB_MS       30
`define AJD_KEEP_CLOSED_MS   600

`define AJD_OHM_STEP0        16'h0018
`define AJD_OHM_STEP1        16'h002a
`define AJD_OHM_STEP2        16'h0064
`define AJD_OHM_STEP3        16'h00c8
`define AJD_OHM_STEP4        16'h01c2
`define AJD_OHM_STEP5        16'h03e8
`define AJD_OHM_LINE_MAX     16'h3a98
`define AJD_STEP_LINE        3'h6

`endif

//--- hw/ajd_pkg.sv
// types shared by the jack detector core and its i2c register port
// assumes the defines header is on the include path
package ajd_pkg;
  `include "ajd_defines.svh"

  typedef enum logic [2:0] {js_no_plug, js_deb_in, js_plugged, js_moist, js_deb_rem} ajd_jack_st_t;

  typedef struct packed {
    ajd_jack_st_t st;
    logic [17:0]  presc;
    logic         tick;
    logic [7:0]   deb_cnt;
    logic [9:0]   poll_cnt;
    logic [9:0]   hold_cnt;
    logic [4:0]   key_cnt;
    logic         key;
    logic         mic;
    logic         ldo;
    logic         irq_n;
    logic [2:0]   step;
    logic         att;
    logic         moist;
    logic [7:0]   ctrl;
    logic [7:0]   timing;
    logic [7:0]   flags;
  } ajd_core_t;

  typedef enum logic [3:0] {i_idle, i_addr, i_aack, i_reg, i_rgack, i_wdata, i_wack, i_rdata,
                            i_rack} ajd_i2c_st_t;

  typedef struct packed {
    ajd_i2c_st_t st;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  bitcnt;
    logic [7:0]  shift;
    logic [7:0]  ptr;
    logic [7:0]  wdata;
    logic        rw;
    logic        oe;
    logic        wr;
    logic        rd;
  } ajd_i2c_t;
endpackage : ajd_pkg

//--- hw/ajd_reg_if.sv
// register access strobes between the i2c port and the detector core
// assumes one clock domain; strobes are one-cycle pulses
`timescale 1ns/1ps
interface ajd_reg_if;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport bus_end (output wr, output rd, output addr, output wdata, input rdata);
  modport reg_end (input wr, input rd, input addr, input wdata, output rdata);
endinterface : ajd_reg_if

//--- hw/ajd_i2c_slave.sv
// i2c register port: device address, register pointer, byte reads and writes
// assumes scl and sda already synchronous to clk_i; sda is open drain
`timescale 1ns/1ps
module ajd_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h35
) (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  output logic        sda_oe_o,
  ajd_reg_if.bus_end  rb
);
  ajd_pkg::ajd_i2c_t s_q;
  ajd_pkg::ajd_i2c_t s_d;

  always_comb
  begin
    s_d       = s_q;
    s_d.wr    = 1'b0;
    s_d.rd    = 1'b0;
    s_d.scl_q = scl_i;
    s_d.sda_q = sda_i;
    if (s_q.scl_q && scl_i && s_q.sda_q && !sda_i)
    begin
      s_d.st     = ajd_pkg::i_addr;
      s_d.bitcnt = 4'h0;
      s_d.oe     = 1'b0;
    end
    else if (s_q.scl_q && scl_i && !s_q.sda_q && sda_i)
    begin
      s_d.st = ajd_pkg::i_idle;
      s_d.oe = 1'b0;
    end
    else if (scl_i && !s_q.scl_q)
    begin
      case (s_q.st)
        ajd_pkg::i_addr, ajd_pkg::i_reg, ajd_pkg::i_wdata:
        begin
          s_d.shift  = {s_q.shift[6:0], sda_i};
          s_d.bitcnt = s_q.bitcnt + 1'b1;
        end
        ajd_pkg::i_rdata:
        begin
          s_d.bitcnt = s_q.bitcnt + 1'b1;
          if (s_q.bitcnt == 4'h0)
            s_d.ptr = s_q.ptr + 1'b1;
        end
        ajd_pkg::i_rack:
          if (sda_i)
            s_d.st = ajd_pkg::i_idle;
        default: ;
      endcase
    end
    else if (!scl_i && s_q.scl_q)
    begin
      case (s_q.st)
        ajd_pkg::i_addr:
          if (s_q.bitcnt == 4'h8)
          begin
            if (s_q.shift[7:1] == DEV_ADDR)
            begin
              s_d.rw = s_q.shift[0];
              s_d.oe = 1'b1;
              s_d.st = ajd_pkg::i_aack;
            end
            else
              s_d.st = ajd_pkg::i_idle;
          end
        ajd_pkg::i_aack, ajd_pkg::i_rack:
          if (s_q.st == ajd_pkg::i_rack || s_q.rw)
          begin
            s_d.shift  = rb.rdata;
            s_d.rd     = 1'b1;
            s_d.oe     = ~rb.rdata[7];
            s_d.bitcnt = 4'h0;
            s_d.st     = ajd_pkg::i_rdata;
          end
          else
          begin
            s_d.oe     = 1'b0;
            s_d.bitcnt = 4'h0;
            s_d.st     = ajd_pkg::i_reg;
          end
        ajd_pkg::i_reg:
          if (s_q.bitcnt == 4'h8)
          begin
            s_d.ptr = s_q.shift;
            s_d.oe  = 1'b1;
            s_d.st  = ajd_pkg::i_rgack;
          end
        ajd_pkg::i_wdata:
          if (s_q.bitcnt == 4'h8)
          begin
            s_d.wr    = 1'b1;
            s_d.wdata = s_q.shift;
            s_d.oe    = 1'b1;
            s_d.st    = ajd_pkg::i_wack;
          end
        ajd_pkg::i_rgack, ajd_pkg::i_wack:
        begin
          if (s_q.st == ajd_pkg::i_wack)
            s_d.ptr = s_q.ptr + 1'b1;
          s_d.oe     = 1'b0;
          s_d.bitcnt = 4'h0;
          s_d.st     = ajd_pkg::i_wdata;
        end
        ajd_pkg::i_rdata:
          if (s_q.bitcnt == 4'h8)
          begin
            s_d.oe = 1'b0;
            s_d.st = ajd_pkg::i_rack;
          end
          else
            s_d.oe = ~s_q.shift[~s_q.bitcnt[2:0]];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      s_q <= '{st: ajd_pkg::i_idle, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    else
      s_q <= s_d;
  end

  assign sda_oe_o = s_q.oe;
  assign rb.wr    = s_q.wr;
  // read strobe in the load cycle, so a flag set then outlives the clear
  assign rb.rd    = s_d.rd;
  assign rb.addr  = s_q.ptr;
  assign rb.wdata = s_q.wdata;
endmodule : ajd_i2c_slave

//--- dv/ajd_host_model.sv
// host side of the i2c register port: start, stop, byte transfers
// assumes sda_i is the pulled-up wire; scl high lasts four clocks, scl low eight
`timescale 1ns/1ps
module ajd_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hp;
    repeat (4) @(posedge clk_i);
  endtask : hp

  task automatic start;
    sda_o <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_o <= 1'b0;
    hp();
    scl_o <= 1'b0;
    hp();
  endtask : start

  task automatic stop;
    sda_o <= 1'b0;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_o <= 1'b1;
    hp();
  endtask : stop

  // data changes only while scl is low
  task automatic bitx(input logic b, output logic s);
    sda_o <= b;
    hp();
    scl_o <= 1'b1;
    hp();
    s = sda_i;
    scl_o <= 1'b0;
    hp();
  endtask : bitx

  task automatic bytex(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic k);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(last, k);
  endtask : bytex

  task automatic wr_reg(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d,
                        output logic nak);
    logic [7:0] q;
    logic       k0, k1, k2;
    start();
    bytex({dv, 1'b0}, 1'b1, q, k0);
    bytex(a, 1'b1, q, k1);
    bytex(d, 1'b1, q, k2);
    stop();
    nak = k0 | k1 | k2;
  endtask : wr_reg

  // pointer write, repeated start, one byte ended by nack
  task automatic rd_reg(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d,
                        output logic nak);
    logic [7:0] q;
    logic       k0, k1, k2, k3;
    start();
    bytex({dv, 1'b0}, 1'b1, q, k0);
    bytex(a, 1'b1, q, k1);
    start();
    bytex({dv, 1'b1}, 1'b1, q, k2);
    bytex(8'hff, 1'b1, d, k3);
    stop();
    nak = k0 | k1 | k2;
  endtask : rd_reg
endmodule : ajd_host_model

//--- dv/ajd_chk.sv
// port checks of the jack detector core
// assumes the insertion debounce field stays at its reset value
`timescale 1ns/1ps
module ajd_chk #(
  parameter int TICK_CYC = 10
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic jack_sense_in_i,
  input wire logic key_cmp_i,
  input wire logic sda_oe_o,
  input wire logic interrupt_request_n_o,
  input wire logic key_press_o,
  input wire logic jack_mic_path_o,
  input wire logic bias_regulator_on_o
);
  localparam int KMAX    = 3 * TICK_CYC + 4;
  localparam int DEB_MIN = 24 * TICK_CYC;
  logic [15:0] low_cnt_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // cycles the sense line has been low
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || jack_sense_in_i)
      low_cnt_q <= 16'h0000;
    else if (low_cnt_q != 16'hffff)
      low_cnt_q <= low_cnt_q + 16'h0001;
  end

  property p_rst;
    $rose(rstn_i) |-> interrupt_request_n_o && !key_press_o && !jack_mic_path_o
                      && !bias_regulator_on_o;
  endproperty
  property p_irq_clear;
    $rose(interrupt_request_n_o) |-> !scl_i && !$past(scl_i);
  endproperty
  property p_debounce;
    $fell(interrupt_request_n_o) && !jack_sense_in_i |-> low_cnt_q >= DEB_MIN;
  endproperty
  property p_mic_open;
    jack_sense_in_i |-> ##2 !jack_mic_path_o;
  endproperty
  property p_key_rise;
    $rose(key_press_o) |-> $past(key_cmp_i) && $past(jack_mic_path_o);
  endproperty
  property p_key_drop;
    $rose(jack_sense_in_i) |-> ##[0:KMAX] !key_press_o;
  endproperty
  property p_ldo;
    $changed(bias_regulator_on_o) |-> !scl_i && !$past(scl_i, 2);
  endproperty
  property p_oe;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty

  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  a_irq_clear: assert property (p_irq_clear) else $error("irq released off a read");
  a_debounce: assert property (p_debounce) else $error("insertion too early");
  a_mic_open: assert property (p_mic_open) else $error("mic closed without plug");
  a_key_rise: assert property (p_key_rise) else $error("key without cause");
  a_key_drop: assert property (p_key_drop) else $error("key held after removal");
  a_ldo: assert property (p_ldo) else $error("regulator moved off a write");
  a_oe: assert property (p_oe) else $error("sda moved while scl high");

  c_irq: cover property (!interrupt_request_n_o ##1 interrupt_request_n_o);
  c_key: cover property ($rose(key_press_o));
  c_poll: cover property ($fell(jack_mic_path_o) && !jack_sense_in_i);
endmodule : ajd_chk

bind ajd_top ajd_chk #(.TICK_CYC(TICK_CYC)) chk_u (.clk_i, .rstn_i, .scl_i, .jack_sense_in_i,
  .key_cmp_i, .sda_oe_o, .interrupt_request_n_o, .key_press_o, .jack_mic_path_o,
  .bias_regulator_on_o);

//--- dv/audio_jack_detect_bench.sv
// bench: registers over i2c, plug, moisture, key and polling
// assumes the host model as i2c master and a pulled-up sda wire
`timescale 1ns/1ps
module audio_jack_detect_bench;
  localparam int         T   = 10;
  localparam logic [6:0] DEV = 7'h35;
  logic        clk_i  = 1'b0;
  logic        rstn_i = 1'b0;
  logic        sense  = 1'b1;
  logic        key    = 1'b0;
  logic [15:0] imp    = 16'h0000;
  logic        scl, sda_h, sda_w, sda_o, sda_oe, irq_n, kp, mic, ldo, nk;
  logic [7:0]  rv;
  logic [15:0] c;
  int          miscompares = 0;
  int          n_tests     = 0;
  int          n;
  logic [15:0] imps [8] = '{16'h0000, 16'h0018, 16'h002a, 16'h0064, 16'h00c8, 16'h01c2,
                            16'h03e8, 16'h3a98};

  always #2 clk_i = ~clk_i;
  assign sda_w = sda_h & (sda_o | ~sda_oe);

  ajd_host_model host_u (.clk_i, .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
  ajd_top #(.TICK_CYC(T), .DEV_ADDR(DEV)) dut_u (.clk_i, .rstn_i, .scl_i(scl), .sda_i(sda_w),
    .sda_o, .sda_oe_o(sda_oe), .jack_sense_in_i(sense), .impedance_ohm_i(imp),
    .key_cmp_i(key), .interrupt_request_n_o(irq_n), .key_press_o(kp),
    .jack_mic_path_o(mic), .bias_regulator_on_o(ldo));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.wr_reg(DEV, a, d, nk);
    chk("write ack", 16'h0000, {15'h0000, nk});
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    host_u.rd_reg(DEV, a, rv, nk);
    chk(nm, {8'h00, e}, {7'h00, nk, rv});
  endtask : rd

  function automatic logic seen(input int s);
    return s == 0 ? ~irq_n : s == 1 ? kp : ~kp;
  endfunction : seen

  task automatic wait_on(input int s, input int lim);
    n = 0;
    while (seen(s) !== 1'b1)
    begin
      if (n == lim)
      begin
        miscompares++;
        $display("CHECK FAILED wait %0d expected 1 seen 0", s);
        give_verdict();
      end
      @(posedge clk_i);
      n++;
    end
  endtask : wait_on

  task automatic cnt;
    c = 16'h0000;
    repeat (1000)
    begin
      @(posedge clk_i);
      c = c + {15'h0000, mic === 1'b1};
    end
  endtask : cnt

  task automatic plug(input logic [15:0] v);
    imp <= v;
    sense <= 1'b0;
    wait_on(0, 27 * T);
  endtask : plug

  task automatic unplug;
    sense <= 1'b1;
    wait_on(0, 3 * T);
    rd("detach", 8'h04, 8'h02);
    rd("gone", 8'h03, 8'h00);
  endtask : unplug

  initial
  begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    chk("irq idle", 16'h0001, {15'h0000, irq_n});
    rd("control", 8'h02, 8'h50);
    rd("timing", 8'h0b, 8'h33);
    rd("status", 8'h03, 8'h00);
    rd("flags", 8'h04, 8'h00);
    rd("unmapped", 8'h07, 8'h00);
    wr(8'h03, 8'hff);
    rd("status ro", 8'h03, 8'h00);
    host_u.wr_reg(7'h12, 8'h02, 8'h51, nk);
    chk("foreign nack", 16'h0001, {15'h0000, nk});
    wr(8'h02, 8'h51);
    chk("ldo on", 16'h0001, {15'h0000, ldo});
    wr(8'h02, 8'h50);
    chk("ldo off", 16'h0000, {15'h0000, ldo});
    for (int i = 0; i < 8; i++)
    begin
      plug(imps[i]);
      chk("debounce", 16'h0001, {15'h0000, n >= 24 * T});
      rd("step", 8'h03, {5'h01, i == 7 ? 3'h6 : 3'(i)});
      rd("attach", 8'h04, 8'h01);
      chk("irq off", 16'h0001, {15'h0000, irq_n});
      chk("mic", {15'h0000, i < 6}, {15'h0000, mic});
      unplug();
    end
    plug(16'h3a99);
    rd("moist st", 8'h03, 8'h10);
    rd("moist fl", 8'h04, 8'h10);
    imp <= 16'h012c;
    wait_on(0, 3 * T + 8);
    rd("late fl", 8'h04, 8'h11);
    rd("late st", 8'h03, 8'h0c);
    unplug();
    plug(16'h0000);
    rd("attach", 8'h04, 8'h01);
    key <= 1'b1;
    wait_on(1, 31 * T + 8);
    chk("key deb", 16'h0001, {15'h0000, n >= 29 * T});
    rd("key st", 8'h03, 8'h28);
    wr(8'h0b, 8'h11);
    wr(8'h02, 8'h52);
    key <= 1'b0;
    wait_on(2, 31 * T + 8);
    repeat (590 * T) @(posedge clk_i);
    chk("mic held", 16'h0001, {15'h0000, mic});
    repeat (20 * T) @(posedge clk_i);
    cnt();
    chk("poll duty", 16'h0064, c);
    rd("key fl", 8'h04, 8'h0c);
    unplug();
    cnt();
    chk("no poll", 16'h0000, c);
    give_verdict();
  end
endmodule : audio_jack_detect_bench
